// *** design/cx_params.svh ***
// cx_params.svh: offsets, field positions, reset values and cycle counts
// assumes inclusion by the execution core and its testbench; definitions only
`ifndef CX_PARAMS_SVH
`define CX_PARAMS_SVH
// register byte offsets
`define OFS_INSN 8'h00
`define OFS_AUX 8'h04
`define OFS_STATUS 8'h08
`define OFS_PC 8'h0c
`define OFS_REGSEL 8'h10
`define OFS_REGDATA 8'h14
`define OFS_INFO 8'h18
// instruction and auxiliary fields, status busy bit
`define INSN_OP 5:0
`define INSN_RD 10:6
`define INSN_RR 15:11
`define INSN_K 23:16
`define AUX_K 11:0
`define AUX_BIT 14:12
`define AUX_TWO 15
`define AUX_IO 23:16
`define STS_BUSY 8
// status flag positions
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_V 3
`define FLG_S 4
`define FLG_H 5
`define FLG_I 7
// Z pointer register pair
`define Z_LO 5'h1e
`define Z_HI 5'h1f
// reset values
`define STATUS_REGISTER_RST 8'h00
`define PC_RST 16'h0000
`define WORD_RST 32'h00000000
`define REGSEL_RST 5'h00
// execution cycle counts
`define CYC_ONE 4'h1
`define CYC_WORD 4'h2
`define CYC_JUMP 4'h2
`define CYC_CALL 4'h3
`define CYC_RET 4'h4
`define CYC_SKIP_ONE 4'h2
`define CYC_SKIP_TWO 4'h3
`define CYC_BR_TAKEN 4'h2
// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// *** design/cx_pkg.sv ***
// cx_pkg: operation and state types of the execution core
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package cx_pkg;
	typedef enum logic [5:0] {
		op_add, op_add_carry, op_word_add_immediate, op_sub, op_subtract_immediate,
		op_subtract_with_borrow, op_subtract_immediate_with_borrow,
		op_word_subtract_immediate, op_and, op_and_immediate, op_or, op_or_immediate,
		op_exclusive_or, op_ones_complement, op_twos_complement, op_bit_set_op,
		op_bit_clear_op, op_inc, op_dec, op_test_zero_minus, op_clear_register_op,
		op_set_register_op, op_relative_jump, op_indirect_jump, op_relative_call,
		op_indirect_call, op_subroutine_return, op_interrupt_return,
		op_compare_skip_equal, op_compare, op_compare_with_carry, op_compare_immediate,
		op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear,
		op_skip_io_bit_set, op_branch_status_bit_set, op_branch_status_bit_clear
	} op_e;
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_fetch = 3'b010,
		st_exec = 3'b100
	} state_e;
endpackage
`default_nettype wire

// *** design/regfile_if.sv ***
// regfile_if: ports between the execution core and the register file
// assumes both ends run on the same clock
`default_nettype none
interface regfile_if;
	logic [4:0] raddr_a;
	logic [4:0] raddr_b;
	logic [4:0] waddr;
	logic [7:0] rdata_a;
	logic [7:0] rdata_b;
	logic [7:0] wdata;
	logic we;
	modport core (output raddr_a, raddr_b, waddr, wdata, we, input rdata_a, rdata_b);
	modport mem (input raddr_a, raddr_b, waddr, wdata, we, output rdata_a, rdata_b);
endinterface
`default_nettype wire

// *** design/regfile_mem.sv ***
// regfile_mem: general register file, two registered reads, one write
// assumes the core holds read addresses stable; contents are not reset
`default_nettype none
module regfile_mem #(
	parameter int DEPTH = 32
) (
	input wire logic aclk,
	regfile_if.mem rf
);
	logic [7:0] cells [DEPTH];

	always_ff @(posedge aclk) begin
		if (rf.we) begin
			cells[rf.waddr] <= rf.wdata;
		end
	end

	always_ff @(posedge aclk) begin
		rf.rdata_a <= cells[rf.raddr_a];
		rf.rdata_b <= cells[rf.raddr_b];
	end
endmodule // regfile_mem
`default_nettype wire

// *** design/core_alu_branch_exec.sv ***
// core_alu_branch_exec: runs one alu, compare, skip, jump, call or return op
// assumes one 100 MHz aclk, synchronous active-low aresetn, AXI4-Lite slave
//
// Local design decisions: the address map and register access over AXI4-Lite.
`include "cx_params.svh"
`default_nettype none
module core_alu_branch_exec #(
	parameter int PC_W = 10,
	parameter int STACK_DEPTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic busy,
	output logic done
);
	regfile_if rf ();
	regfile_mem #(.DEPTH(32)) mem (.aclk(aclk), .rf(rf));

	cx_pkg::state_e state, next_state;
	cx_pkg::op_e op_q;
	logic [3:0] cnt, total, total_q, cyc_last;
	logic [31:0] insn_q, aux_q, wdata_q, rd_mux;
	logic [7:0] awaddr_q, status_register, next_status_register, a, src, k8, io_byte;
	logic [3:0] wstrb_q;
	logic [4:0] regsel, rd_q, rr_q;
	logic [PC_W-1:0] pc, npc;
	logic [PC_W-1:0] stack [STACK_DEPTH];
	logic [$clog2(STACK_DEPTH)-1:0] sp;
	logic [15:0] res, res_q, pair;
	logic [8:0] sum9, dif9, neg9;
	logic [11:0] k12;
	logic [2:0] bsel;
	logic cin, wr_res, push, pop, skip, logic_fl, lv, two_word, first, fin, do_write;
	logic w_insn, w_aux, w_sts, w_pc, w_regsel, w_regdata;

	function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) m[8*i +: 8] = nw[8*i +: 8];
		end
		return m;
	endfunction

	function automatic logic mapped(input logic [7:0] ad);
		return ad inside {`OFS_INSN, `OFS_AUX, `OFS_STATUS, `OFS_PC, `OFS_REGSEL,
			`OFS_REGDATA, `OFS_INFO};
	endfunction

	function automatic logic is_word(input cx_pkg::op_e o);
		return o inside {cx_pkg::op_word_add_immediate, cx_pkg::op_word_subtract_immediate};
	endfunction

	function automatic logic [3:0] add_hvnc(input logic [7:0] x, input logic [7:0] y,
			input logic [7:0] r, input logic co);
		return {x[3] & y[3] | y[3] & ~r[3] | ~r[3] & x[3],
			x[7] & y[7] & ~r[7] | ~x[7] & ~y[7] & r[7], r[7], co};
	endfunction

	function automatic logic [3:0] sub_hvnc(input logic [7:0] x, input logic [7:0] y,
			input logic [7:0] r, input logic bo);
		return {~x[3] & y[3] | y[3] & r[3] | r[3] & ~x[3],
			x[7] & ~y[7] & ~r[7] | ~x[7] & y[7] & r[7], r[7], bo};
	endfunction

	// field views
	assign op_q = cx_pkg::op_e'(insn_q[`INSN_OP]);
	assign rd_q = insn_q[`INSN_RD];
	assign rr_q = insn_q[`INSN_RR];
	assign k8 = insn_q[`INSN_K];
	assign k12 = aux_q[`AUX_K];
	assign bsel = aux_q[`AUX_BIT];
	assign two_word = aux_q[`AUX_TWO];
	assign io_byte = aux_q[`AUX_IO];

	// AXI4-Lite write channel: address and data in either order
	assign do_write = !awready && !wready && !bvalid;
	assign w_insn = do_write && awaddr_q == `OFS_INSN && state == cx_pkg::st_idle;
	assign w_aux = do_write && awaddr_q == `OFS_AUX && state == cx_pkg::st_idle;
	assign w_sts = do_write && awaddr_q == `OFS_STATUS && state == cx_pkg::st_idle;
	assign w_pc = do_write && awaddr_q == `OFS_PC && state == cx_pkg::st_idle;
	assign w_regsel = do_write && awaddr_q == `OFS_REGSEL;
	assign w_regdata = do_write && awaddr_q == `OFS_REGDATA && state == cx_pkg::st_idle;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= `WORD_RST;
			wstrb_q <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awaddr_q <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
				wready <= 1'b0;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel
	always_comb begin
		case (araddr)
			`OFS_INSN: rd_mux = insn_q;
			`OFS_AUX: rd_mux = aux_q;
			`OFS_STATUS: rd_mux = {23'h000000, busy, status_register};
			`OFS_PC: rd_mux = 32'(pc);
			`OFS_REGSEL: rd_mux = {27'h0000000, regsel};
			`OFS_REGDATA: rd_mux = {24'h000000, rf.rdata_a};
			`OFS_INFO: rd_mux = {24'h000000, 4'(sp), cyc_last};
			default: rd_mux = `WORD_RST;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= `WORD_RST;
			rresp <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// software-visible control words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			insn_q <= `WORD_RST;
			aux_q <= `WORD_RST;
			regsel <= `REGSEL_RST;
		end else begin
			if (w_insn) insn_q <= lanes(insn_q, wdata_q, wstrb_q);
			if (w_aux) aux_q <= lanes(aux_q, wdata_q, wstrb_q);
			if (w_regsel && wstrb_q[0]) regsel <= wdata_q[4:0];
		end
	end

	// sequencing: idle, operand fetch, execute for the instruction's cycles
	assign first = state == cx_pkg::st_exec && cnt == 4'h1;
	assign fin = state == cx_pkg::st_exec && (first ? total == `CYC_ONE : cnt == total_q);

	always_comb begin
		case (state)
			cx_pkg::st_idle: next_state = w_insn ? cx_pkg::st_fetch : cx_pkg::st_idle;
			cx_pkg::st_fetch: next_state = cx_pkg::st_exec;
			cx_pkg::st_exec: next_state = fin ? cx_pkg::st_idle : cx_pkg::st_exec;
			default: next_state = cx_pkg::st_idle;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= cx_pkg::st_idle;
			cnt <= 4'h0;
			total_q <= `CYC_ONE;
			cyc_last <= 4'h0;
			busy <= 1'b0;
			done <= 1'b0;
			res_q <= 16'h0000;
		end else begin
			state <= next_state;
			busy <= next_state != cx_pkg::st_idle;
			done <= fin;
			cnt <= (state == cx_pkg::st_exec) ? cnt + 4'h1 : 4'h1;
			if (first) begin
				total_q <= total;
				res_q <= res;
			end
			if (fin) cyc_last <= cnt;
		end
	end

	// operand addresses: pair for word ops, Z for indirect ops
	always_comb begin
		rf.raddr_a = rd_q;
		rf.raddr_b = rr_q;
		if (state == cx_pkg::st_idle) begin
			rf.raddr_a = regsel;
		end else if (is_word(op_q)) begin
			rf.raddr_b = rd_q + 5'h01;
		end else if (op_q inside {cx_pkg::op_indirect_jump, cx_pkg::op_indirect_call}) begin
			rf.raddr_a = `Z_LO;
			rf.raddr_b = `Z_HI;
		end
	end

	// result, flags, next pc and cycle count, valid in the first exec cycle
	always_comb begin
		a = rf.rdata_a;
		src = (op_q inside {cx_pkg::op_subtract_immediate, cx_pkg::op_compare_immediate,
			cx_pkg::op_subtract_immediate_with_borrow, cx_pkg::op_and_immediate,
			cx_pkg::op_or_immediate, cx_pkg::op_bit_set_op}) ? k8 : rf.rdata_b;
		cin = status_register[`FLG_C] & (op_q inside {cx_pkg::op_add_carry, cx_pkg::op_compare_with_carry,
			cx_pkg::op_subtract_with_borrow, cx_pkg::op_subtract_immediate_with_borrow});
		sum9 = {1'b0, a} + {1'b0, src} + {8'h00, cin};
		dif9 = {1'b0, a} - {1'b0, src} - {8'h00, cin};
		neg9 = 9'h000 - {1'b0, a};
		pair = {rf.rdata_b, a};
		next_status_register = status_register;
		res = 16'h0000;
		wr_res = 1'b0;
		logic_fl = 1'b0;
		lv = 1'b0;
		skip = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		npc = pc + 1'b1;
		total = `CYC_ONE;
		case (op_q)
			cx_pkg::op_add, cx_pkg::op_add_carry: begin
				res = {8'h00, sum9[7:0]};
				wr_res = 1'b1;
				{next_status_register[`FLG_H], next_status_register[`FLG_V], next_status_register[`FLG_N], next_status_register[`FLG_C]} =
					add_hvnc(a, src, sum9[7:0], sum9[8]);
				next_status_register[`FLG_Z] = sum9[7:0] == 8'h00;
			end
			cx_pkg::op_sub, cx_pkg::op_subtract_immediate, cx_pkg::op_subtract_with_borrow,
			cx_pkg::op_subtract_immediate_with_borrow, cx_pkg::op_compare,
			cx_pkg::op_compare_with_carry, cx_pkg::op_compare_immediate: begin
				res = {8'h00, dif9[7:0]};
				wr_res = !(op_q inside {cx_pkg::op_compare, cx_pkg::op_compare_with_carry,
					cx_pkg::op_compare_immediate});
				{next_status_register[`FLG_H], next_status_register[`FLG_V], next_status_register[`FLG_N], next_status_register[`FLG_C]} =
					sub_hvnc(a, src, dif9[7:0], dif9[8]);
				next_status_register[`FLG_Z] = dif9[7:0] == 8'h00 &&
					(status_register[`FLG_Z] || !(op_q inside {cx_pkg::op_subtract_with_borrow,
					cx_pkg::op_subtract_immediate_with_borrow, cx_pkg::op_compare_with_carry}));
			end
			cx_pkg::op_twos_complement: begin
				res = {8'h00, neg9[7:0]};
				wr_res = 1'b1;
				{next_status_register[`FLG_H], next_status_register[`FLG_V], next_status_register[`FLG_N], next_status_register[`FLG_C]} =
					sub_hvnc(8'h00, a, neg9[7:0], neg9[8]);
				next_status_register[`FLG_Z] = neg9[7:0] == 8'h00;
			end
			cx_pkg::op_word_add_immediate, cx_pkg::op_word_subtract_immediate: begin
				res = (op_q == cx_pkg::op_word_add_immediate) ? pair + {10'h000, k8[5:0]} :
					pair - {10'h000, k8[5:0]};
				wr_res = 1'b1;
				total = `CYC_WORD;
				next_status_register[`FLG_N] = res[15];
				next_status_register[`FLG_Z] = res == 16'h0000;
				next_status_register[`FLG_V] = (op_q == cx_pkg::op_word_add_immediate) ?
					~pair[15] & res[15] : pair[15] & ~res[15];
				next_status_register[`FLG_C] = (op_q == cx_pkg::op_word_add_immediate) ?
					pair[15] & ~res[15] : res[15] & ~pair[15];
				next_status_register[`FLG_S] = res[15] ^ next_status_register[`FLG_V];
			end
			cx_pkg::op_and, cx_pkg::op_and_immediate, cx_pkg::op_test_zero_minus: begin
				res = {8'h00, a & src};
				if (op_q == cx_pkg::op_test_zero_minus) res = {8'h00, a & a};
				wr_res = 1'b1;
				logic_fl = 1'b1;
			end
			cx_pkg::op_or, cx_pkg::op_or_immediate, cx_pkg::op_bit_set_op: begin
				res = {8'h00, a | src};
				wr_res = 1'b1;
				logic_fl = 1'b1;
			end
			cx_pkg::op_exclusive_or, cx_pkg::op_clear_register_op: begin
				res = {8'h00, a ^ src};
				if (op_q == cx_pkg::op_clear_register_op) res = {8'h00, a ^ a};
				wr_res = 1'b1;
				logic_fl = 1'b1;
			end
			cx_pkg::op_bit_clear_op: begin
				res = {8'h00, a & ~k8};
				wr_res = 1'b1;
				logic_fl = 1'b1;
			end
			cx_pkg::op_ones_complement: begin
				res = {8'h00, ~a};
				wr_res = 1'b1;
				logic_fl = 1'b1;
				next_status_register[`FLG_C] = 1'b1;
			end
			cx_pkg::op_inc, cx_pkg::op_dec: begin
				res = {8'h00, (op_q == cx_pkg::op_inc) ? a + 8'h01 : a - 8'h01};
				wr_res = 1'b1;
				logic_fl = 1'b1;
				lv = (op_q == cx_pkg::op_inc) ? a == 8'h7f : a == 8'h80;
			end
			cx_pkg::op_set_register_op: begin
				res = 16'h00ff;
				wr_res = 1'b1;
			end
			cx_pkg::op_relative_jump: begin
				npc = pc + k12[PC_W-1:0] + 1'b1;
				total = `CYC_JUMP;
			end
			cx_pkg::op_indirect_jump: begin
				npc = pair[PC_W-1:0];
				total = `CYC_JUMP;
			end
			cx_pkg::op_relative_call, cx_pkg::op_indirect_call: begin
				npc = (op_q == cx_pkg::op_relative_call) ? pc + k12[PC_W-1:0] + 1'b1 :
					pair[PC_W-1:0];
				push = 1'b1;
				total = `CYC_CALL;
			end
			cx_pkg::op_subroutine_return, cx_pkg::op_interrupt_return: begin
				npc = stack[sp - 1'b1];
				pop = 1'b1;
				total = `CYC_RET;
				if (op_q == cx_pkg::op_interrupt_return) next_status_register[`FLG_I] = 1'b1;
			end
			cx_pkg::op_compare_skip_equal: skip = a == rf.rdata_b;
			cx_pkg::op_skip_reg_bit_clear: skip = !a[bsel];
			cx_pkg::op_skip_reg_bit_set: skip = a[bsel];
			cx_pkg::op_skip_io_bit_clear: skip = !io_byte[bsel];
			cx_pkg::op_skip_io_bit_set: skip = io_byte[bsel];
			cx_pkg::op_branch_status_bit_set, cx_pkg::op_branch_status_bit_clear: begin
				if (status_register[bsel] == (op_q == cx_pkg::op_branch_status_bit_set)) begin
					npc = pc + k12[PC_W-1:0] + 1'b1;
					total = `CYC_BR_TAKEN;
				end
			end
			default: ;
		endcase
		if (logic_fl) begin
			next_status_register[`FLG_Z] = res[7:0] == 8'h00;
			next_status_register[`FLG_N] = res[7];
			next_status_register[`FLG_V] = lv;
		end
		if (skip) begin
			npc = pc + (two_word ? 2'h3 : 2'h2);
			total = two_word ? `CYC_SKIP_TWO : `CYC_SKIP_ONE;
		end
	end

	// register file write: low byte on the first exec cycle, high byte next
	always_comb begin
		rf.we = 1'b0;
		rf.waddr = rd_q;
		rf.wdata = res[7:0];
		if (first && wr_res) begin
			rf.we = 1'b1;
		end else if (state == cx_pkg::st_exec && cnt == 4'h2 && is_word(op_q)) begin
			rf.we = 1'b1;
			rf.waddr = rd_q + 5'h01;
			rf.wdata = res_q[15:8];
		end else if (w_regdata && wstrb_q[0]) begin
			rf.we = 1'b1;
			rf.waddr = regsel;
			rf.wdata = wdata_q[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_register <= `STATUS_REGISTER_RST;
		end else if (first) begin
			status_register <= next_status_register;
		end else if (w_sts && wstrb_q[0]) begin
			status_register <= wdata_q[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc <= PC_W'(`PC_RST);
		end else if (first) begin
			pc <= npc;
		end else if (w_pc) begin
			pc <= PC_W'(lanes(32'(pc), wdata_q, wstrb_q));
		end
	end

	// return stack, wraps when over- or under-used
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sp <= '0;
		end else if (first && push) begin
			stack[sp] <= pc + 1'b1;
			sp <= sp + 1'b1;
		end else if (first && pop) begin
			sp <= sp - 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_one;
		state == cx_pkg::st_exec ##1 state == cx_pkg::st_idle;
	endsequence
	sequence s_two;
		state == cx_pkg::st_exec [*2] ##1 state == cx_pkg::st_idle;
	endsequence

	a_add_timing: assert property (
		(state == cx_pkg::st_fetch && op_q inside {cx_pkg::op_add, cx_pkg::op_add_carry})
		|=> s_one) else $error("add did not finish in one cycle");
	a_word_timing: assert property (
		(state == cx_pkg::st_fetch && is_word(op_q))
		|=> s_two ##0 status_register[`FLG_H] == $past(status_register[`FLG_H], 3))
		else $error("word op length or half-carry wrong");
	a_sub_keeps_it: assert property (
		(first && op_q == cx_pkg::op_sub) |=> $stable(status_register[`FLG_I]) && status_register[`FLG_C] ==
		($past(rf.rdata_a) < $past(rf.rdata_b))) else $error("subtract borrow wrong");
	a_logic_overflow: assert property (
		(first && op_q inside {cx_pkg::op_and, cx_pkg::op_or, cx_pkg::op_exclusive_or})
		|=> !status_register[`FLG_V] && $stable(status_register[`FLG_C])) else $error("logic flags wrong");
	a_clear_bits: assert property (
		(first && op_q == cx_pkg::op_bit_clear_op) |-> rf.we && rf.wdata == (a & ~k8))
		else $error("bit clear value wrong");
	a_set_reg: assert property (
		(first && op_q == cx_pkg::op_set_register_op) |-> rf.wdata == 8'hff ##1 $stable(status_register))
		else $error("set register wrong");
	a_inc_overflow: assert property (
		(first && op_q == cx_pkg::op_inc) |=> status_register[`FLG_V] == ($past(a) == 8'h7f))
		else $error("increment overflow wrong");
	a_relative_jump_target: assert property (
		(state == cx_pkg::st_fetch && op_q == cx_pkg::op_relative_jump)
		|=> ##1 pc == PC_W'($past(pc, 2) + k12[PC_W-1:0] + 1'b1)) else $error("jump target wrong");
	a_ret_timing: assert property (
		(state == cx_pkg::st_fetch && op_q inside {cx_pkg::op_subroutine_return,
		cx_pkg::op_interrupt_return})
		|=> state == cx_pkg::st_exec [*4] ##1 state == cx_pkg::st_idle)
		else $error("return not four cycles");
	a_compare_skip_equal_noskip: assert property (
		(first && op_q == cx_pkg::op_compare_skip_equal && a != rf.rdata_b) |=> !busy)
		else $error("unequal compare-skip too long");
	a_cmp_nowrite: assert property (
		(first && op_q == cx_pkg::op_compare) |-> !rf.we) else $error("compare wrote result");
	a_branch_idle: assert property (
		(first && op_q == cx_pkg::op_branch_status_bit_set && !status_register[bsel]) |=> !busy)
		else $error("untaken branch too long");
	a_skip_two: assert property (
		(first && skip && two_word) |-> ##2 fin ##1 !busy) else $error("two-word skip length");
endmodule // core_alu_branch_exec
`default_nettype wire

// *** tb/core_alu_branch_exec_test.sv ***
// core_alu_branch_exec_test: runs ops through the register bus and checks results
// assumes the design files are compiled first and cx_params.svh is on the include path
`include "cx_params.svh"
`default_nettype none
module core_alu_branch_exec_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, busy, done;
	logic [31:0] rdata, v;
	logic [1:0] bresp, rresp, resp;
	int failures = 0;
	int tests_run = 0;
	int pulses = 0;
	always #5 aclk = ~aclk;
	core_alu_branch_exec uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .busy(busy), .done(done));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// every done pulse ends one launched op, and busy has already fallen
	always @(posedge aclk) begin
		if (done === 1'b1) begin
			pulses++;
			chk({31'h0, busy}, 32'h0);
		end
	end
	// loads operands, status and pc, launches one op, then checks status, pc, cycle count and register d
	task automatic run(input cx_pkg::op_e op, input logic [4:0] d, input logic [4:0] r,
		input logic [7:0] a, input logic [7:0] b, input logic [7:0] k, input logic [23:0] x,
		input logic [7:0] s0, input logic [7:0] res, input logic [7:0] sr,
		input logic [9:0] p0, input logic [9:0] p, input logic [3:0] c);
		wr(`OFS_REGSEL, {27'h0, d});
		wr(`OFS_REGDATA, {24'h0, a});
		wr(`OFS_REGSEL, {27'h0, r});
		wr(`OFS_REGDATA, {24'h0, b});
		wr(`OFS_STATUS, {24'h0, s0});
		wr(`OFS_PC, {22'h0, p0});
		wr(`OFS_AUX, {8'h0, x});
		wr(`OFS_INSN, {8'h00, k, r, d, op});
		v = 32'h100;
		while (v[`STS_BUSY] !== 1'b0) rd(`OFS_STATUS);
		chk(v, {24'h0, sr});
		rd(`OFS_PC);
		chk(v, {22'h0, p});
		rd(`OFS_INFO);
		chk({28'h0, v[3:0]}, {28'h0, c});
		wr(`OFS_REGSEL, {27'h0, d});
		rd(`OFS_REGDATA);
		chk(v, {24'h0, res});
		$display("test %s done", op.name());
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`OFS_STATUS);
		chk(v, 32'h0);
		rd(`OFS_PC);
		chk(v, 32'h0);
		run(cx_pkg::op_add, 5'h01, 5'h02, 8'h0f, 8'h01, 8'h00, 24'h0, 8'h00, 8'h10, 8'h20,
			10'h010, 10'h011, 4'h1);
		run(cx_pkg::op_sub, 5'h01, 5'h02, 8'h00, 8'h01, 8'h00, 24'h0, 8'h00, 8'hff, 8'h25,
			10'h010, 10'h011, 4'h1);
		run(cx_pkg::op_and, 5'h01, 5'h02, 8'hf0, 8'h0f, 8'h00, 24'h0, 8'h01, 8'h00, 8'h03,
			10'h010, 10'h011, 4'h1);
		run(cx_pkg::op_set_register_op, 5'h01, 5'h02, 8'h12, 8'h34, 8'h00, 24'h0, 8'hff,
			8'hff, 8'hff, 10'h010, 10'h011, 4'h1);
		run(cx_pkg::op_compare, 5'h01, 5'h02, 8'h05, 8'h05, 8'h00, 24'h0, 8'h01, 8'h05,
			8'h02, 10'h010, 10'h011, 4'h1);
		run(cx_pkg::op_word_add_immediate, 5'h18, 5'h19, 8'hff, 8'h00, 8'h01, 24'h0, 8'h20,
			8'h00, 8'h20, 10'h010, 10'h011, 4'h2);
		run(cx_pkg::op_relative_jump, 5'h01, 5'h02, 8'h05, 8'h06, 8'h00, 24'h005, 8'h00,
			8'h05, 8'h00, 10'h010, 10'h016, 4'h2);
		run(cx_pkg::op_compare_skip_equal, 5'h01, 5'h02, 8'h05, 8'h05, 8'h00, 24'h008000,
			8'h3f, 8'h05, 8'h3f, 10'h010, 10'h013, 4'h3);
		run(cx_pkg::op_branch_status_bit_set, 5'h01, 5'h02, 8'h05, 8'h06, 8'h00, 24'h001003,
			8'h02, 8'h05, 8'h02, 10'h010, 10'h014, 4'h2);
		run(cx_pkg::op_branch_status_bit_clear, 5'h01, 5'h02, 8'h05, 8'h06, 8'h00,
			24'h001003, 8'h02, 8'h05, 8'h02, 10'h010, 10'h011, 4'h1);
		run(cx_pkg::op_bit_clear_op, 5'h01, 5'h02, 8'hff, 8'h00, 8'h0f, 24'h0, 8'h09,
			8'hf0, 8'h05, 10'h010, 10'h011, 4'h1);
		run(cx_pkg::op_inc, 5'h01, 5'h02, 8'h7f, 8'h00, 8'h00, 24'h0, 8'h00,
			8'h80, 8'h0c, 10'h010, 10'h011, 4'h1);
		run(cx_pkg::op_ones_complement, 5'h01, 5'h02, 8'h0f, 8'h00, 8'h00, 24'h0, 8'h08,
			8'hf0, 8'h05, 10'h010, 10'h011, 4'h1);
		run(cx_pkg::op_compare_skip_equal, 5'h01, 5'h02, 8'h05, 8'h06, 8'h00, 24'h008000,
			8'h3f, 8'h05, 8'h3f, 10'h010, 10'h011, 4'h1);
		run(cx_pkg::op_skip_reg_bit_clear, 5'h01, 5'h02, 8'h05, 8'h06, 8'h00, 24'h001000,
			8'h00, 8'h05, 8'h00, 10'h010, 10'h012, 4'h2);
		run(cx_pkg::op_branch_status_bit_set, 5'h01, 5'h02, 8'h05, 8'h06, 8'h00, 24'h001003,
			8'h00, 8'h05, 8'h00, 10'h010, 10'h011, 4'h1);
		run(cx_pkg::op_indirect_jump, 5'h1e, 5'h1f, 8'h34, 8'h01, 8'h00, 24'h0, 8'h00,
			8'h34, 8'h00, 10'h010, 10'h134, 4'h2);
		run(cx_pkg::op_word_subtract_immediate, 5'h18, 5'h19, 8'h00, 8'h00, 8'h01, 24'h0,
			8'h20, 8'hff, 8'h35, 10'h010, 10'h011, 4'h2);
		run(cx_pkg::op_skip_io_bit_set, 5'h01, 5'h02, 8'h05, 8'h06, 8'h00, 24'h807000,
			8'h00, 8'h05, 8'h00, 10'h010, 10'h012, 4'h2);
		run(cx_pkg::op_relative_call, 5'h01, 5'h02, 8'h05, 8'h06, 8'h00, 24'h020, 8'h00,
			8'h05, 8'h00, 10'h010, 10'h031, 4'h3);
		run(cx_pkg::op_interrupt_return, 5'h01, 5'h02, 8'h05, 8'h06, 8'h00, 24'h0, 8'h00,
			8'h05, 8'h80, 10'h020, 10'h011, 4'h4);
		wr(`OFS_INFO, 32'hff);
		chk({30'h0, resp}, {30'h0, `RESP_OKAY});
		rd(`OFS_INFO);
		chk({28'h0, v[3:0]}, 32'h4);
		rd(8'h1c);
		chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
		chk(v, 32'h0);
		wr(8'h1c, 32'h1);
		chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
		chk(pulses, 32'h15);
		$display("test bus done");
		close_out();
	end
endmodule // core_alu_branch_exec_test
`default_nettype wire
